/* verilog/ppm_consts.svh */
// Constants for the power-mode control block: offsets, fields, defaults, counts.
// Behaviour
// - Power-saving enabled by 1Fh bit 10; active only with autoneg on and no link.
// - Power-saving switches off all blocks except transmitter, energy detector and PLL.
// - Power-saving is off after power-up.
// - Energy-detect power-down enabled by clearing 18h bit 11; needs autoneg, no link.
// - With 10h bit 4 set, PLL turns off during energy-detect power-down.
// - Energy-detect power-down keeps sending periodic link pulses.
// - Energy-detect power-down is disabled after power-up.
// - Setting 0h bit 11 enters power-down.
// - Power-down disables everything except the management register interface.
// - Clearing 0h bit 11 leaves power-down.
// - Setting 11h bit 5 selects the on-chip slow oscillator instead of crystal_input.
// - Slow oscillator plus power-down gives lowest power, management still works.
// - Mode bits live in a 32-entry register space reached by the controller.
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------------
`define PPM_IDX_BASIC_CTRL   5'h00
`define PPM_IDX_DIGI_CTRL    5'h10
`define PPM_IDX_AFE_CTRL     5'h11
`define PPM_IDX_EXT_CTRL     5'h18
`define PPM_IDX_MODE_STATUS  5'h19
`define PPM_IDX_PHY_CTRL2    5'h1f

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define PPM_BIT_SOFT_RESET   15
`define PPM_BIT_AUTONEG_EN   12
`define PPM_BIT_POWER_DOWN   11
`define PPM_BIT_PLL_AUTO_OFF 4
`define PPM_BIT_SLOW_OSC     5
`define PPM_BIT_ENERGY_DETECT_POWER_DOWN_DIS     11
`define PPM_BIT_POWER_SAVE   10

// ----------------------------------------------------------------------------
// Reset values and timing counts.
// ----------------------------------------------------------------------------
`define PPM_RST_AUTONEG_EN   1'b1
`define PPM_RST_ENERGY_DETECT_POWER_DOWN_DIS     1'b1
`define PPM_RST_POWER_SAVE   1'b0
`define PPM_SRST_CYCLES      8'h10
`define PPM_PULSE_CYCLES     32'h001e_8480

`endif

/* verilog/ppm_pkg.sv */
// Types shared by the power-mode control block.
package ppm_pkg;

  typedef enum logic [0:0] {
    PPM_RUN,
    PPM_SRESET
  } ppm_phase_type;

  typedef struct packed {
    ppm_phase_type phase;
    logic          autoneg_en;
    logic          power_down;
    logic          soft_reset;
    logic          pll_auto_off;
    logic          slow_osc;
    logic          energy_detect_power_down_dis;
    logic          power_save;
    logic          link_meta;
    logic          link_sync;
    logic [7:0]    srst_cnt;
    logic [31:0]   pulse_cnt;
    logic          pulse;
    logic          ack;
    logic [15:0]   rdata;
    logic          rx_en;
    logic          tx_en;
    logic          edet_en;
    logic          pll_en;
  } ppm_state_type;

endpackage

/* verilog/ppm_power_mode_ctrl.sv */
// Power-mode controller with a classic Wishbone register slave.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ppm_consts.svh"

module ppm_power_mode_ctrl #(
  parameter logic [31:0] PULSE_CYCLES = `PPM_PULSE_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [6:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        link_up_i,
  output logic             rx_blocks_en_o,
  output logic             tx_en_o,
  output logic             energy_det_en_o,
  output logic             pll_en_o,
  output logic             slow_osc_sel_o,
  output logic             link_pulse_o,
  output logic             soft_reset_o
);

  ppm_pkg::ppm_state_type state_reg;
  ppm_pkg::ppm_state_type state_next;

  logic       req;
  logic       wr;
  logic [4:0] idx;
  logic       an_nolink;
  logic       energy_detect_power_down_act;
  logic       psave_act;
  logic       srst_wr;

  assign req = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign wr  = req && wb_we_i;
  assign idx = wb_adr_i[6:2];
  assign srst_wr = wr && idx == `PPM_IDX_BASIC_CTRL && wb_sel_i[1]
                   && wb_dat_i[`PPM_BIT_SOFT_RESET];

  // --------------------------------------------------------------------------
  // Mode resolution.
  // --------------------------------------------------------------------------
  assign an_nolink = state_reg.autoneg_en && !state_reg.link_sync;
  assign energy_detect_power_down_act  = !state_reg.energy_detect_power_down_dis && an_nolink;
  assign psave_act = state_reg.power_save && an_nolink;

  always_comb begin
    state_next           = state_reg;
    state_next.link_meta = link_up_i;
    state_next.link_sync = state_reg.link_meta;
    state_next.ack       = req;
    state_next.pulse     = 1'b0;

    // ----------------------------------------------------------------------
    // Register writes; each field lives in the byte lane that holds it.
    // ----------------------------------------------------------------------
    if (wr && idx == `PPM_IDX_BASIC_CTRL) begin
      if (wb_sel_i[1]) begin
        state_next.autoneg_en = wb_dat_i[`PPM_BIT_AUTONEG_EN];
        state_next.power_down = wb_dat_i[`PPM_BIT_POWER_DOWN];
        if (wb_dat_i[`PPM_BIT_SOFT_RESET]) begin
          state_next.soft_reset = 1'b1;
          state_next.phase      = ppm_pkg::PPM_SRESET;
          state_next.srst_cnt   = `PPM_SRST_CYCLES;
        end
      end
    end else if (wr && idx == `PPM_IDX_DIGI_CTRL) begin
      if (wb_sel_i[0]) begin
        state_next.pll_auto_off = wb_dat_i[`PPM_BIT_PLL_AUTO_OFF];
      end
    end else if (wr && idx == `PPM_IDX_AFE_CTRL) begin
      if (wb_sel_i[0]) begin
        state_next.slow_osc = wb_dat_i[`PPM_BIT_SLOW_OSC];
      end
    end else if (wr && idx == `PPM_IDX_EXT_CTRL) begin
      if (wb_sel_i[1]) begin
        state_next.energy_detect_power_down_dis = wb_dat_i[`PPM_BIT_ENERGY_DETECT_POWER_DOWN_DIS];
      end
    end else if (wr && idx == `PPM_IDX_PHY_CTRL2) begin
      if (wb_sel_i[1]) begin
        state_next.power_save = wb_dat_i[`PPM_BIT_POWER_SAVE];
      end
    end

    // ----------------------------------------------------------------------
    // Read data; unmapped indices read as zero.
    // ----------------------------------------------------------------------
    state_next.rdata = 16'h0000;
    if (idx == `PPM_IDX_BASIC_CTRL) begin
      state_next.rdata[`PPM_BIT_SOFT_RESET] = state_reg.soft_reset;
      state_next.rdata[`PPM_BIT_AUTONEG_EN] = state_reg.autoneg_en;
      state_next.rdata[`PPM_BIT_POWER_DOWN] = state_reg.power_down;
    end else if (idx == `PPM_IDX_DIGI_CTRL) begin
      state_next.rdata[`PPM_BIT_PLL_AUTO_OFF] = state_reg.pll_auto_off;
    end else if (idx == `PPM_IDX_AFE_CTRL) begin
      state_next.rdata[`PPM_BIT_SLOW_OSC] = state_reg.slow_osc;
    end else if (idx == `PPM_IDX_EXT_CTRL) begin
      state_next.rdata[`PPM_BIT_ENERGY_DETECT_POWER_DOWN_DIS] = state_reg.energy_detect_power_down_dis;
    end else if (idx == `PPM_IDX_MODE_STATUS) begin
      state_next.rdata[5:0] = {state_reg.phase == ppm_pkg::PPM_SRESET,
                               state_reg.slow_osc, state_reg.power_down,
                               energy_detect_power_down_act, psave_act, state_reg.link_sync};
    end else if (idx == `PPM_IDX_PHY_CTRL2) begin
      state_next.rdata[`PPM_BIT_POWER_SAVE] = state_reg.power_save;
    end

    // ----------------------------------------------------------------------
    // Software reset sequence; the bit clears itself when the count ends.
    // ----------------------------------------------------------------------
    case (state_reg.phase)
      ppm_pkg::PPM_RUN: begin
      end
      ppm_pkg::PPM_SRESET: begin
        if (state_reg.srst_cnt == 8'h00) begin
          state_next.phase        = ppm_pkg::PPM_RUN;
          state_next.soft_reset   = 1'b0;
          state_next.autoneg_en   = `PPM_RST_AUTONEG_EN;
          state_next.power_down   = 1'b0;
          state_next.pll_auto_off = 1'b0;
          state_next.slow_osc     = 1'b0;
          state_next.energy_detect_power_down_dis     = `PPM_RST_ENERGY_DETECT_POWER_DOWN_DIS;
          state_next.power_save   = `PPM_RST_POWER_SAVE;
        end else begin
          state_next.srst_cnt = state_reg.srst_cnt - 8'h01;
        end
      end
      default: begin
        state_next.phase = ppm_pkg::PPM_RUN;
      end
    endcase

    // A new request in the cycle that the old reset ends restarts the count,
    // so the set is never lost to the self-clear.
    if (srst_wr) begin
      state_next.soft_reset = 1'b1;
      state_next.phase      = ppm_pkg::PPM_SRESET;
      state_next.srst_cnt   = `PPM_SRST_CYCLES;
    end

    // ----------------------------------------------------------------------
    // Periodic link pulses while waiting in energy-detect power-down.
    // ----------------------------------------------------------------------
    if (energy_detect_power_down_act && !state_reg.power_down) begin
      if (state_reg.pulse_cnt >= PULSE_CYCLES - 32'h1) begin
        state_next.pulse_cnt = 32'h0;
        state_next.pulse     = 1'b1;
      end else begin
        state_next.pulse_cnt = state_reg.pulse_cnt + 32'h1;
      end
    end else begin
      state_next.pulse_cnt = 32'h0;
    end

    // ----------------------------------------------------------------------
    // Sub-block enables; power-down wins over every other mode.
    // ----------------------------------------------------------------------
    state_next.rx_en   = 1'b1;
    state_next.tx_en   = 1'b1;
    state_next.edet_en = 1'b1;
    state_next.pll_en  = 1'b1;
    if (state_reg.power_down) begin
      state_next.rx_en   = 1'b0;
      state_next.tx_en   = 1'b0;
      state_next.edet_en = 1'b0;
      state_next.pll_en  = 1'b0;
    end else if (energy_detect_power_down_act) begin
      state_next.rx_en  = 1'b0;
      state_next.pll_en = !state_reg.pll_auto_off;
    end else if (psave_act) begin
      state_next.rx_en = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg              <= '0;
      state_reg.phase        <= ppm_pkg::PPM_RUN;
      state_reg.autoneg_en   <= `PPM_RST_AUTONEG_EN;
      state_reg.energy_detect_power_down_dis     <= `PPM_RST_ENERGY_DETECT_POWER_DOWN_DIS;
      state_reg.power_save   <= `PPM_RST_POWER_SAVE;
      state_reg.rx_en        <= 1'b1;
      state_reg.tx_en        <= 1'b1;
      state_reg.edet_en      <= 1'b1;
      state_reg.pll_en       <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs.
  // --------------------------------------------------------------------------
  assign wb_ack_o        = state_reg.ack;
  assign wb_dat_o        = {16'h0000, state_reg.rdata};
  assign rx_blocks_en_o  = state_reg.rx_en;
  assign tx_en_o         = state_reg.tx_en;
  assign energy_det_en_o = state_reg.edet_en;
  assign pll_en_o        = state_reg.pll_en;
  assign slow_osc_sel_o  = state_reg.slow_osc;
  assign link_pulse_o    = state_reg.pulse;
  assign soft_reset_o    = state_reg.soft_reset;

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_pd_all_off: assert property (
    $past(state_reg.power_down) |-> !tx_en_o && !rx_blocks_en_o
      && !pll_en_o && !energy_det_en_o)
    else $error("power-down left a block enabled");

  a_pd_enter: assert property (
    wr && idx == `PPM_IDX_BASIC_CTRL && wb_sel_i[1]
      && wb_dat_i[`PPM_BIT_POWER_DOWN] && state_reg.phase == ppm_pkg::PPM_RUN
      |=> ##1 !tx_en_o)
    else $error("power-down write did not stop transmitter");

  a_pd_exit: assert property (
    wr && idx == `PPM_IDX_BASIC_CTRL && wb_sel_i[1]
      && !wb_dat_i[`PPM_BIT_POWER_DOWN] && !wb_dat_i[`PPM_BIT_SOFT_RESET]
      |=> ##1 tx_en_o)
    else $error("power-down did not end after clear");

  a_energy_detect_power_down_pll: assert property (
    $past(energy_detect_power_down_act && state_reg.pll_auto_off && !state_reg.power_down)
      |-> !pll_en_o && tx_en_o && energy_det_en_o && !rx_blocks_en_o)
    else $error("energy-detect power-down enables wrong");

  a_psave_blocks: assert property (
    $past(psave_act && !energy_detect_power_down_act && !state_reg.power_down)
      |-> !rx_blocks_en_o && tx_en_o && pll_en_o && energy_det_en_o)
    else $error("power-saving enables wrong");

  a_pulse_energy_detect_power_down: assert property (
    link_pulse_o |-> $past(energy_detect_power_down_act && !state_reg.power_down))
    else $error("link pulse outside energy-detect power-down");

  a_srst_clears: assert property (
    $rose(soft_reset_o) |-> soft_reset_o [*8] ##[1:20] !soft_reset_o
      && !slow_osc_sel_o && !state_reg.power_down)
    else $error("software reset did not self-clear to defaults");

  a_ack_one: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_link_gate: assert property (
    $past(state_reg.link_sync && !state_reg.power_down)
      |-> rx_blocks_en_o && tx_en_o && pll_en_o && energy_det_en_o)
    else $error("low-power mode active with link up");

  // --------------------------------------------------------------------------
  // Mode checks.
  // --------------------------------------------------------------------------
  a_an_off_full: assert property (
    $past(!state_reg.autoneg_en && !state_reg.power_down)
      |-> rx_blocks_en_o && tx_en_o && pll_en_o && energy_det_en_o)
    else $error("low-power mode active with autoneg off");

  a_tx_kept: assert property (
    $past(!state_reg.power_down) |-> tx_en_o && energy_det_en_o)
    else $error("transmitter or energy detector off outside power-down");

  a_psave_write: assert property (
    wr && idx == `PPM_IDX_PHY_CTRL2 && wb_sel_i[1]
      && state_reg.phase == ppm_pkg::PPM_RUN
      |=> state_reg.power_save == $past(wb_dat_i[`PPM_BIT_POWER_SAVE]))
    else $error("power-saving bit did not follow write");

  a_energy_detect_power_down_write: assert property (
    wr && idx == `PPM_IDX_EXT_CTRL && wb_sel_i[1]
      && state_reg.phase == ppm_pkg::PPM_RUN
      |=> state_reg.energy_detect_power_down_dis == $past(wb_dat_i[`PPM_BIT_ENERGY_DETECT_POWER_DOWN_DIS]))
    else $error("energy-detect disable bit did not follow write");

  a_energy_detect_power_down_pll_on: assert property (
    $past(energy_detect_power_down_act && !state_reg.pll_auto_off && !state_reg.power_down)
      |-> pll_en_o && !rx_blocks_en_o)
    else $error("PLL off in energy-detect power-down without auto-off");

  a_pulse_gap: assert property (
    PULSE_CYCLES > 32'h1 && link_pulse_o |=> !link_pulse_o)
    else $error("link pulses too close together");

  a_pulse_pd: assert property (
    $past(state_reg.power_down) |-> !link_pulse_o)
    else $error("link pulse during power-down");

  a_psave_reset: assert property (
    $past(rst_i) |-> !state_reg.power_save)
    else $error("power-saving set after reset");

  a_energy_detect_power_down_reset: assert property (
    $past(rst_i) |-> state_reg.energy_detect_power_down_dis)
    else $error("energy-detect power-down enabled after reset");

  a_slow_write: assert property (
    wr && idx == `PPM_IDX_AFE_CTRL && wb_sel_i[0]
      && state_reg.phase == ppm_pkg::PPM_RUN
      |=> slow_osc_sel_o == $past(wb_dat_i[`PPM_BIT_SLOW_OSC]))
    else $error("slow oscillator select did not follow write");

  // --------------------------------------------------------------------------
  // Register bus and software reset checks.
  // --------------------------------------------------------------------------
  a_lowest_mgmt: assert property (
    state_reg.power_down && state_reg.slow_osc && req |=> wb_ack_o)
    else $error("management access lost in lowest power state");

  a_pd_readback: assert property (
    state_reg.power_down && req && !wb_we_i
      && idx == `PPM_IDX_EXT_CTRL
      |=> wb_dat_o[`PPM_BIT_ENERGY_DETECT_POWER_DOWN_DIS] == $past(state_reg.energy_detect_power_down_dis))
    else $error("register read wrong during power-down");

  a_ack_answer: assert property (
    req |=> wb_ack_o)
    else $error("request not acknowledged in one cycle");

  a_srst_start: assert property (
    srst_wr |=> soft_reset_o)
    else $error("software reset write did not start a reset");

  a_srst_hold: assert property (
    soft_reset_o && state_reg.srst_cnt != 8'h00 |=> soft_reset_o)
    else $error("software reset ended before its count");

  a_srst_defaults: assert property (
    $fell(soft_reset_o) |-> state_reg.energy_detect_power_down_dis && !state_reg.power_save
      && !state_reg.power_down && !slow_osc_sel_o
      && !state_reg.pll_auto_off)
    else $error("software reset end left a mode bit set");

endmodule
`default_nettype wire

/* bench/ppm_mgmt_model.sv */
// Management controller model: a classic Wishbone master.
`timescale 1ns/1ps
`default_nettype none
module ppm_mgmt_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [6:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 7'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // One access to a 16-bit register; the index sits in bits 6:2.
  task automatic xfer(input logic we, input logic [4:0] i,
                      input logic [15:0] d);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= we;
    adr_o <= {i, 2'b00};
    sel_o <= 4'h3;
    dat_o <= {16'h0000, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~dat_o;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* bench/phy_power_mode_control_tb_top.sv */
// Self-checking bench for the power-mode controller.
`timescale 1ns/1ps
`default_nettype none
module phy_power_mode_control_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        link_up_i = 1'b0;
  logic        cyc, stb, we, ack, rx, tx, ed, pll, slow, pulse, srst;
  logic [6:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [15:0] exp_q[$];
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          pulses = 0;
  int          srst_len = 0;
  int          n = 0;
  int          seed = 67;

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  ppm_power_mode_ctrl #(.PULSE_CYCLES(32'h0000_0014)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .link_up_i(link_up_i),
    .rx_blocks_en_o(rx), .tx_en_o(tx), .energy_det_en_o(ed),
    .pll_en_o(pll), .slow_osc_sel_o(slow), .link_pulse_o(pulse),
    .soft_reset_o(srst));

  ppm_mgmt_model u_mgmt (
    .clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  task automatic bad(input string m);
    failures++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) bad(m);
  endtask

  task automatic results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    u_mgmt.xfer(1'b1, i, d);
  endtask

  task automatic rd(input logic [4:0] i, input logic [15:0] e);
    exp_q.push_back(e);
    u_mgmt.xfer(1'b0, i, 16'h0000);
  endtask

  // Order of the bits: receive, transmit, energy detect, PLL.
  task automatic en(input logic [3:0] e);
    repeat (6) @(posedge clk_i);
    chk({rx, tx, ed, pll} === e, "enables");
  endtask

  // Read results are matched against the oldest noted expectation.
  always @(posedge clk_i) begin
    cycles++;
    // Non-blocking counts let the main sequence read them without a race.
    if (pulse === 1'b1) pulses <= pulses + 1;
    if (srst === 1'b1) srst_len <= srst_len + 1;
    if (ack === 1'b1 && we === 1'b0) begin
      chk(exp_q.size() != 0 && rdat === {16'h0000, exp_q[0]}, "read");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    if (cycles == 5000) begin
      bad("timeout");
      results();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(5'h00, 16'h1000);
    rd(5'h18, 16'h0800);
    rd(5'h1f, 16'h0000);
    en(4'hf);
    wr(5'h05, 16'($random(seed)));
    rd(5'h05, 16'h0000);
    wr(5'h1f, 16'h0400);
    en(4'h7);
    link_up_i <= 1'b1;
    en(4'hf);
    link_up_i <= 1'b0;
    wr(5'h00, 16'h0000);
    en(4'hf);
    wr(5'h00, 16'h1000);
    wr(5'h18, 16'h0000);
    en(4'h7);
    wr(5'h10, 16'h0010);
    en(4'h6);
    n = pulses;
    repeat (60) @(posedge clk_i);
    chk(pulses - n == 3, "pulse count");
    wr(5'h00, 16'h1800);
    en(4'h0);
    rd(5'h18, 16'h0000);
    wr(5'h11, 16'h0020);
    en(4'h0);
    chk(slow === 1'b1, "slow osc on");
    rd(5'h11, 16'h0020);
    wr(5'h11, 16'h0000);
    wr(5'h00, 16'h1000);
    en(4'h6);
    chk(slow === 1'b0, "slow osc off");
    wr(5'h00, 16'h9000);
    repeat (30) @(posedge clk_i);
    chk(srst_len == 17, "soft reset length");
    rd(5'h18, 16'h0800);
    rd(5'h10, 16'h0000);
    en(4'hf);
    results();
  end
endmodule
`default_nettype wire
